// *** verilog/tsal_pkg.sv ***
`default_nettype none
package tsal_pkg;

	// Values taken after power-up and after a general-call reset
	localparam logic [15:0] LOW_LIMIT_RST  = 16'h4b00;
	localparam logic [15:0] HIGH_LIMIT_RST = 16'h5000;
	localparam logic        MODE_RST       = 1'b0;
	localparam logic        POL_RST        = 1'b0;
	localparam logic [1:0]  DEPTH_RST      = 2'h0;

	// Bus bytes and address layout
	localparam logic [7:0] ARA_BYTE      = 8'h19;
	localparam logic [7:0] GC_BYTE       = 8'h00;
	localparam logic [7:0] GC_CMD_LATCH  = 8'h04;
	localparam logic [7:0] GC_CMD_RESET  = 8'h06;
	localparam logic [3:0] ADDR_UPPER    = 4'h9;
	localparam logic [3:0] BYTE_BITS     = 4'h8;

	// Cycles after reset release before the address pins are caught
	localparam logic [1:0] STRAP_WAIT    = 2'h2;

	// Timing
	localparam int CLK_PERIOD_NS       = 50;
	localparam int BUS_TIMEOUT_NS_DEF  = 30000000;
	localparam int POR_TIME_NS_DEF     = 500000;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ARA,
		ST_ACK_GC,
		ST_ACK_OWN,
		ST_GC_CMD,
		ST_ACK_CMD,
		ST_ARA_TX,
		ST_IGNORE
	} tsal_state_t;

	// Consecutive faults needed for each queue depth code
	function automatic logic [2:0] tsal_depth(input logic [1:0] code);
		logic [2:0] n;
		n = 3'h1;
		unique case (code)
			2'h0: n = 3'h1;
			2'h1: n = 3'h2;
			2'h2: n = 3'h4;
			2'h3: n = 3'h6;
		endcase
		return n;
	endfunction

endpackage
`default_nettype wire

// *** verilog/tsal_fault_q.sv ***
`timescale 1ns/100ps
`default_nettype none
module tsal_fault_q
	import tsal_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic       ce_in,
	input  wire logic       clr_in,
	input  wire logic       sample_in,
	input  wire logic       fault_in,
	input  wire logic [1:0] depth_in,
	output logic            hit_out
);

	logic [2:0] count_reg;

	// Queue reaches depth on this faulty sample
	assign hit_out = sample_in && fault_in && !clr_in
		&& ((count_reg + 3'h1) >= tsal_depth(depth_in)); // [R21]

	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
			count_reg <= 3'h0;
		else if (ce_in)
		begin
			if (clr_in || hit_out) // [R3]
				count_reg <= 3'h0;
			else if (sample_in)
				count_reg <= fault_in ? count_reg + 3'h1 : 3'h0; // [R21]
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_limit_clr_count: assert property ( // [R3]
		ce_in && clr_in |=> count_reg == 3'h0)
		else $error("fault count not cleared");
	a_depth_reached: assert property ( // [R21]
		hit_out |-> count_reg + 3'h1 >= tsal_depth(depth_in)
			&& count_reg < 3'h6)
		else $error("fault queue hit at wrong count");

endmodule
`default_nettype wire

// *** verilog/tsal_alert_core.sv ***
// Functional notes
// [R1] Reset loads low 4b00h, high 5000h
// [R2] Controller keeps high limit above low limit
// [R3] Changing either limit clears fault counter
// [R4] Bus alert only in interrupt, active-low
// [R5] Alerting device acknowledges alert response byte
// [R6] Then sends address 1001 plus pins
// [R7] Eighth bit: one high, zero low
// [R8] Arbitration: lowest address wins
// [R9] Winner releases alert after sending address
// [R10] Loser does not acknowledge, keeps alert
// [R11] Controller repeats alert response until clear
// [R12] Clock low too long resets interface
// [R13] Fresh start recognised before maximum timeout
// [R14] General call only with write bit
// [R15] Acknowledge general call, await command
// [R16] Command 04h re-latches address pins
// [R17] Command 06h re-latches and resets
// [R18] Reset restores defaults, busy bounded time
// [R19] Mode bit: zero comparator, one interrupt
// [R20] Polarity bit: zero low, one high
// [R21] Alarm after 1, 2, 4, 6 faults
// [R22] Address drive only low, stop on loss
// [R23] Timeout counter threshold is a parameter
// [R24] No own-address acknowledge while resetting
`timescale 1ns/100ps
`default_nettype none
module tsal_alert_core
	import tsal_pkg::*;
#(
	parameter int BUS_TIMEOUT_NS = BUS_TIMEOUT_NS_DEF,
	parameter int POR_TIME_NS    = POR_TIME_NS_DEF
)
(
	input  wire logic        CLOCK_IN,
	input  wire logic        NRST_IN,
	input  wire logic        CE_IN,
	input  wire logic        SCL_IN,
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE_OUT,
	input  wire logic [2:0]  ADDRESS_SELECT_PINS_IN,
	input  wire logic        CFG_WR_IN,
	input  wire logic        THERMOSTAT_MODE_SELECT_IN,
	input  wire logic        ALARM_POLARITY_IN,
	input  wire logic [1:0]  FAULT_QUEUE_DEPTH_IN,
	input  wire logic        LOW_LIMIT_WR_IN,
	input  wire logic        HIGH_LIMIT_WR_IN,
	input  wire logic [15:0] LIMIT_DATA_IN,
	input  wire logic        TEMP_VALID_IN,
	input  wire logic [15:0] TEMP_IN,
	output logic [15:0]      LOW_LIMIT_OUT,
	output logic [15:0]      HIGH_LIMIT_OUT,
	output logic [6:0]       SLAVE_ADDR_OUT,
	output logic             ALERT_OUT,
	output logic             BUSY_OUT
);

	// Timeout threshold sits between the bus minimum and maximum
	localparam int TO_CYC  = BUS_TIMEOUT_NS / CLK_PERIOD_NS; // [R23]
	localparam int TO_W    = $clog2(TO_CYC + 1);
	localparam int POR_CYC = POR_TIME_NS / CLK_PERIOD_NS;
	localparam int POR_W   = $clog2(POR_CYC + 1);

	logic [1:0]      scl_sync_reg;
	logic [1:0]      sda_sync_reg;
	logic [2:0]      pin_sync1_reg;
	logic [2:0]      pin_sync2_reg;
	logic            scl_d_reg;
	logic            sda_d_reg;
	logic [1:0]      strap_wait_reg;
	logic [2:0]      addr_reg;
	tsal_state_t     state_reg;
	logic [7:0]      shift_reg;
	logic [7:0]      tx_reg;
	logic [3:0]      bit_cnt_reg;
	logic            sda_oe_reg;
	logic [TO_W-1:0] scl_low_cnt_reg;
	logic [POR_W-1:0] busy_cnt_reg;
	logic            busy_reg;
	logic [15:0]     low_reg;
	logic [15:0]     high_reg;
	logic            mode_reg;
	logic            pol_reg;
	logic [1:0]      depth_reg;
	logic            comp_state_reg;
	logic            look_high_reg;
	logic            alert_pend_reg;
	logic            limit_bit_reg;
	logic            alert_out_reg;

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic timeout;
	logic ara_en;
	logic ara_win;
	logic gc_exec;
	logic gc_latch;
	logic gc_reset;
	logic limit_chg;
	logic target_high;
	logic fault;
	logic fault_hit;
	logic alarm_active;

	assign scl_s      = scl_sync_reg[1];
	assign sda_s      = sda_sync_reg[1];
	assign scl_rise   = scl_s && !scl_d_reg;
	assign scl_fall   = !scl_s && scl_d_reg;
	assign start_seen = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign stop_seen  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
	assign timeout    = scl_low_cnt_reg == TO_W'(TO_CYC); // [R12]
	assign ara_en     = mode_reg && !pol_reg; // [R4]
	assign ara_win    = state_reg == ST_ARA_TX && scl_fall
		&& bit_cnt_reg == BYTE_BITS; // [R9]
	assign gc_exec    = state_reg == ST_ACK_CMD && scl_fall;
	assign gc_latch   = gc_exec && (shift_reg == GC_CMD_LATCH
		|| shift_reg == GC_CMD_RESET); // [R16] [R17]
	assign gc_reset   = gc_exec && shift_reg == GC_CMD_RESET; // [R17]
	assign limit_chg  = (LOW_LIMIT_WR_IN && LIMIT_DATA_IN != low_reg)
		|| (HIGH_LIMIT_WR_IN && LIMIT_DATA_IN != high_reg); // [R3]

	// Pins from outside the clock domain
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
		end
		else if (CE_IN)
		begin
			scl_sync_reg <= {scl_sync_reg[0], SCL_IN};
			sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
			scl_d_reg    <= scl_s;
			sda_d_reg    <= sda_s;
		end
	end

	// Straps keep sampling in reset so the first latch sees them
	always_ff @(posedge CLOCK_IN)
	begin
		if (CE_IN)
		begin
			pin_sync1_reg <= ADDRESS_SELECT_PINS_IN;
			pin_sync2_reg <= pin_sync1_reg;
		end
	end

	// Address pins caught after reset release and on general-call commands 04h and 06h
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			strap_wait_reg <= 2'h0;
			addr_reg       <= 3'h0;
		end
		else if (CE_IN)
		begin
			if (strap_wait_reg != STRAP_WAIT)
				strap_wait_reg <= strap_wait_reg + 2'h1;
			if (strap_wait_reg == STRAP_WAIT - 2'h1 || gc_latch) // [R16]
				addr_reg <= pin_sync2_reg;
		end
	end

	// Clock-low timeout counter
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
			scl_low_cnt_reg <= '0;
		else if (CE_IN)
		begin
			if (scl_s)
				scl_low_cnt_reg <= '0;
			else if (!timeout)
				scl_low_cnt_reg <= scl_low_cnt_reg + TO_W'(1); // [R23]
		end
	end

	// Serial interface
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			state_reg   <= ST_IDLE;
			shift_reg   <= 8'h00;
			tx_reg      <= 8'h00;
			bit_cnt_reg <= 4'h0;
			sda_oe_reg  <= 1'b0;
		end
		else if (CE_IN)
		begin
			if (timeout)
			begin
				// Back to idle so the next start is seen at once
				state_reg  <= ST_IDLE; // [R12] [R13]
				sda_oe_reg <= 1'b0;
			end
			else if (start_seen)
			begin
				state_reg   <= ST_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_oe_reg  <= 1'b0;
			end
			else if (stop_seen)
			begin
				state_reg  <= ST_IDLE;
				sda_oe_reg <= 1'b0;
			end
			else
			begin
				unique case (state_reg)
					ST_IDLE, ST_IGNORE:
						sda_oe_reg <= 1'b0;
					ST_ADDR, ST_GC_CMD:
						if (scl_rise)
						begin
							shift_reg   <= {shift_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						else if (scl_fall && bit_cnt_reg == BYTE_BITS)
						begin
							sda_oe_reg <= 1'b1;
							if (state_reg == ST_GC_CMD)
								state_reg <= ST_ACK_CMD;
							else if (shift_reg == ARA_BYTE && ara_en
								&& alert_pend_reg)
								state_reg <= ST_ACK_ARA; // [R5]
							else if (shift_reg == GC_BYTE)
								state_reg <= ST_ACK_GC; // [R14] [R15]
							else if (shift_reg[7:1] == {ADDR_UPPER, addr_reg}
								&& !busy_reg)
								state_reg <= ST_ACK_OWN; // [R24]
							else
							begin
								state_reg  <= ST_IGNORE;
								sda_oe_reg <= 1'b0;
							end
						end
					ST_ACK_ARA:
						if (scl_fall)
						begin
							state_reg   <= ST_ARA_TX;
							bit_cnt_reg <= 4'h0;
							tx_reg      <= {ADDR_UPPER, addr_reg,
								limit_bit_reg}; // [R6] [R7]
							sda_oe_reg  <= !ADDR_UPPER[3]; // [R22]
						end
					ST_ACK_GC:
						if (scl_fall)
						begin
							state_reg   <= ST_GC_CMD; // [R15]
							bit_cnt_reg <= 4'h0;
							sda_oe_reg  <= 1'b0;
						end
					ST_ACK_OWN, ST_ACK_CMD:
						if (scl_fall)
						begin
							state_reg  <= ST_IGNORE;
							sda_oe_reg <= 1'b0;
						end
					ST_ARA_TX:
						if (scl_rise)
						begin
							if (tx_reg[7] && !sda_s)
							begin
								// Lost to a lower address
								state_reg  <= ST_IGNORE; // [R8] [R10] [R22]
								sda_oe_reg <= 1'b0;
							end
							else
								bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						else if (scl_fall)
						begin
							if (bit_cnt_reg == BYTE_BITS)
							begin
								state_reg  <= ST_IGNORE;
								sda_oe_reg <= 1'b0;
							end
							else
							begin
								tx_reg     <= {tx_reg[6:0], 1'b0};
								sda_oe_reg <= !tx_reg[6]; // [R22]
							end
						end
				endcase
			end
		end
	end

	// General-call reset busy window
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			busy_cnt_reg <= '0;
			busy_reg     <= 1'b0;
		end
		else if (CE_IN)
		begin
			if (gc_reset)
			begin
				busy_cnt_reg <= POR_W'(POR_CYC - 1); // [R18]
				busy_reg     <= 1'b1;
			end
			else if (busy_cnt_reg != '0)
				busy_cnt_reg <= busy_cnt_reg - POR_W'(1);
			else
				busy_reg <= 1'b0;
		end
	end

	// Limits and configuration
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN || (CE_IN && busy_reg))
		begin
			low_reg   <= LOW_LIMIT_RST; // [R1] [R18]
			high_reg  <= HIGH_LIMIT_RST; // [R1] [R18]
			mode_reg  <= MODE_RST; // [R19]
			pol_reg   <= POL_RST; // [R20]
			depth_reg <= DEPTH_RST;
		end
		else if (CE_IN)
		begin
			if (LOW_LIMIT_WR_IN)
				low_reg <= LIMIT_DATA_IN;
			if (HIGH_LIMIT_WR_IN)
				high_reg <= LIMIT_DATA_IN;
			if (CFG_WR_IN)
			begin
				mode_reg  <= THERMOSTAT_MODE_SELECT_IN;
				pol_reg   <= ALARM_POLARITY_IN;
				depth_reg <= FAULT_QUEUE_DEPTH_IN;
			end
		end
	end

	// Limit under watch: high until tripped, then low
	assign target_high = mode_reg ? look_high_reg : !comp_state_reg; // [R19]
	assign fault = target_high
		? $signed(TEMP_IN) >= $signed(high_reg)
		: $signed(TEMP_IN) < $signed(low_reg);

	tsal_fault_q u_fault_q (
		.clk_in    (CLOCK_IN),
		.nrst_in   (NRST_IN),
		.ce_in     (CE_IN),
		.clr_in    (limit_chg || busy_reg),
		.sample_in (TEMP_VALID_IN),
		.fault_in  (fault),
		.depth_in  (depth_reg),
		.hit_out   (fault_hit)
	);

	// Alarm state; a new event beats a same-cycle clear
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN || (CE_IN && busy_reg))
		begin
			comp_state_reg <= 1'b0;
			look_high_reg  <= 1'b1;
			alert_pend_reg <= 1'b0;
			limit_bit_reg  <= 1'b0;
		end
		else if (CE_IN)
		begin
			if (fault_hit && !mode_reg)
				comp_state_reg <= !comp_state_reg;
			if (fault_hit && mode_reg)
			begin
				alert_pend_reg <= 1'b1;
				limit_bit_reg  <= target_high; // [R7]
				look_high_reg  <= !look_high_reg;
			end
			else if (ara_win)
				alert_pend_reg <= 1'b0; // [R9]
		end
	end

	assign alarm_active = mode_reg ? alert_pend_reg : comp_state_reg;

	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
			alert_out_reg <= 1'b1;
		else if (CE_IN)
			alert_out_reg <= pol_reg ? alarm_active : !alarm_active; // [R20]
	end

	assign SDA_OUT        = 1'b0;
	assign SDA_OE_OUT     = sda_oe_reg;
	assign LOW_LIMIT_OUT  = low_reg;
	assign HIGH_LIMIT_OUT = high_reg;
	assign SLAVE_ADDR_OUT = {ADDR_UPPER, addr_reg};
	assign ALERT_OUT      = alert_out_reg;
	assign BUSY_OUT       = busy_reg;

	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!NRST_IN);

	a_limit_defaults: assert property ( // [R1]
		$rose(NRST_IN) |-> low_reg == 16'h4b00 && high_reg == 16'h5000)
		else $error("limits not at defaults after reset");
	a_ara_mode_gate: assert property ( // [R4]
		$rose(state_reg == ST_ACK_ARA) |-> $past(ara_en))
		else $error("alert response outside interrupt active-low");
	a_ara_ack_drive: assert property ( // [R5]
		CE_IN && state_reg == ST_ADDR && scl_fall && bit_cnt_reg == BYTE_BITS
		&& shift_reg == ARA_BYTE && ara_en && alert_pend_reg
		|=> sda_oe_reg && state_reg == ST_ACK_ARA)
		else $error("alert response byte not acknowledged");
	a_ara_addr_byte: assert property ( // [R6]
		$rose(state_reg == ST_ARA_TX)
		|-> tx_reg == {4'h9, addr_reg, limit_bit_reg})
		else $error("wrong address in alert response");
	a_drive_only_zero: assert property ( // [R22]
		state_reg == ST_ARA_TX && sda_oe_reg |-> !tx_reg[7])
		else $error("driving line for a one bit");
	a_arb_loss: assert property ( // [R10]
		CE_IN && state_reg == ST_ARA_TX && scl_rise && tx_reg[7] && !sda_s
		|=> state_reg == ST_IGNORE && !sda_oe_reg
		&& (alert_pend_reg || busy_reg))
		else $error("lost arbitration not handled");
	a_win_release: assert property ( // [R9]
		CE_IN && ara_win && !fault_hit |=> !alert_pend_reg)
		else $error("alert kept after winning");
	a_bus_timeout: assert property ( // [R12]
		CE_IN && timeout |=> state_reg == ST_IDLE && !sda_oe_reg)
		else $error("interface not freed on timeout");
	a_gc_read_nak: assert property ( // [R14]
		CE_IN && state_reg == ST_ADDR && scl_fall
		&& bit_cnt_reg == BYTE_BITS && shift_reg == 8'h01
		&& !start_seen && !stop_seen && !timeout |=> !sda_oe_reg)
		else $error("general call read acknowledged");
	a_gc_reset_busy: assert property ( // [R17] [R18]
		CE_IN && gc_reset && !timeout |=> busy_reg ##1 low_reg == 16'h4b00
		&& high_reg == 16'h5000 && !mode_reg)
		else $error("general call reset not applied");
	a_busy_no_ack: assert property ( // [R24]
		busy_reg |-> state_reg != ST_ACK_OWN)
		else $error("own address acknowledged while busy");

	c_ara_win: cover property (ara_win);
	c_ara_lost: cover property (state_reg == ST_ARA_TX ##1
		state_reg == ST_IGNORE && bit_cnt_reg != BYTE_BITS);
	c_gc_reset: cover property (gc_reset);
	c_timeout: cover property (timeout && state_reg != ST_IDLE);

endmodule
`default_nettype wire

// *** bench/tsal_bus_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module tsal_bus_master
(
	output logic      scl_out,
	output logic      sda_out,
	input  wire logic sda_in
);
	localparam time Q = 100;

	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	task automatic start;
		sda_out = 1'b1;
		#Q scl_out = 1'b1;
		#Q sda_out = 1'b0;
		#Q scl_out = 1'b0;
	endtask

	task automatic stop;
		#Q sda_out = 1'b0;
		#Q scl_out = 1'b1;
		#Q sda_out = 1'b1;
		#Q;
	endtask

	task automatic wbit(input logic b);
		#Q sda_out = b;
		#Q scl_out = 1'b1;
		#(2*Q) scl_out = 1'b0;
	endtask

	// Rival pulls low where its own address bit is zero
	task automatic rbit(input logic rv, output logic b);
		#Q sda_out = ~rv;
		#Q scl_out = 1'b1;
		#Q b = sda_in;
		#Q scl_out = 1'b0;
	endtask

	task automatic wbyte(input logic [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--)
			wbit(v[i]);
		rbit(1'b0, ack);
	endtask

	task automatic rbyte(input logic [8:0] rv, output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			rbit(rv[8] & ~rv[i], d[i]);
	endtask
endmodule
`default_nettype wire

// *** bench/tsal_alert_core_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tsal_alert_core_tb
	import tsal_pkg::*;
;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b1;
	logic        cfg_wr = 1'b0;
	logic        mode = 1'b0;
	logic        alarm_polarity = 1'b0;
	logic        lo_wr = 1'b0;
	logic        hi_wr = 1'b0;
	logic        tv = 1'b0;
	logic [1:0]  depth = 2'h0;
	logic [2:0]  pins = 3'h5;
	logic [15:0] ldata = 16'h0000;
	logic [15:0] temp = 16'h0000;
	wire logic   scl;
	wire logic   m_sda;
	wire logic   sda_w;
	logic        oe;
	logic        sda_o;
	logic        alert;
	logic        busy;
	logic [15:0] lo;
	logic [15:0] hi;
	logic [6:0]  sa;
	logic        a;
	logic [7:0]  d;
	int          err_count = 0;
	int          n_tests = 0;
	int          c;
	localparam logic [17:0] ROWS [4] = '{{1'b0, 16'h5000, 1'b0},
		{1'b0, 16'h4c00, 1'b0}, {1'b0, 16'h4a00, 1'b1},
		{1'b1, 16'h4a00, 1'b0}};
	localparam int NS [4] = '{1, 2, 4, 6};
	localparam logic [7:0] OWN_WR = 8'h9c;

	// Open-drain data line with pull-up
	assign sda_w = m_sda & ~oe;
	always #25 clk = ~clk;

	tsal_alert_core #(.BUS_TIMEOUT_NS(2000), .POR_TIME_NS(20000)) uut
	(
		.CLOCK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .SCL_IN(scl),
		.SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE_OUT(oe),
		.ADDRESS_SELECT_PINS_IN(pins), .CFG_WR_IN(cfg_wr),
		.THERMOSTAT_MODE_SELECT_IN(mode), .ALARM_POLARITY_IN(alarm_polarity),
		.FAULT_QUEUE_DEPTH_IN(depth), .LOW_LIMIT_WR_IN(lo_wr),
		.HIGH_LIMIT_WR_IN(hi_wr), .LIMIT_DATA_IN(ldata),
		.TEMP_VALID_IN(tv), .TEMP_IN(temp), .LOW_LIMIT_OUT(lo),
		.HIGH_LIMIT_OUT(hi), .SLAVE_ADDR_OUT(sa), .ALERT_OUT(alert),
		.BUSY_OUT(busy)
	);

	tsal_bus_master m
	(
		.scl_out(scl),
		.sda_out(m_sda),
		.sda_in(sda_w)
	);

	task automatic chk(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic summarize;
		$display("Tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tick;
		@(posedge clk);
		#1;
	endtask

	task automatic set_cfg(input logic mo, po, input logic [1:0] dp);
		mode = mo;
		alarm_polarity = po;
		depth = dp;
		cfg_wr = 1'b1;
		tick;
		cfg_wr = 1'b0;
		tick;
	endtask

	task automatic feed(input logic [15:0] t);
		temp = t;
		tv = 1'b1;
		tick;
		tv = 1'b0;
		repeat (4) tick;
	endtask

	task automatic ara(input logic [8:0] rv);
		m.start;
		m.wbyte(ARA_BYTE, a);
		if (a === 1'b0)
			m.rbyte(rv, d);
		m.wbit(1'b1);
		m.stop;
		repeat (4) tick;
	endtask

	task automatic gc(input logic [7:0] b, output logic ak);
		m.start;
		m.wbyte(b, ak);
	endtask

	task automatic wait_low(input bit on_oe, input int lim);
		c = 0;
		while ((on_oe ? oe : busy) !== 1'b0 && c < lim)
		begin
			tick;
			c++;
		end
		if (c >= lim)
		begin
			err_count++;
			summarize;
		end
	endtask

	initial
	begin
		repeat (6) tick;
		nrst = 1'b1;
		repeat (6) tick;
		chk("low limit", 16'h4b00, lo);
		chk("high limit", 16'h5000, hi);
		chk("alert idle", 1'b1, alert);
		chk("slave addr", {4'h9, 3'h5}, sa);
		for (int i = 0; i < 4; i++)
		begin
			set_cfg(1'b0, ROWS[i][17], 2'h0);
			feed(ROWS[i][16:1]);
			chk("row alert", ROWS[i][0], alert);
		end
		for (int i = 0; i < 4; i++)
		begin
			set_cfg(1'b0, 1'b0, i[1:0]);
			repeat (NS[i] - 1) feed(16'h5000);
			chk("depth short", 1'b1, alert);
			feed(16'h5000);
			chk("depth hit", 1'b0, alert);
			repeat (NS[i]) feed(16'h4a00);
			chk("depth clear", 1'b1, alert);
		end
		set_cfg(1'b0, 1'b0, 2'h1);
		// Samples while disabled must not count
		ce = 1'b0;
		repeat (2) feed(16'h5000);
		ce = 1'b1;
		chk("frozen", 1'b1, alert);
		feed(16'h5000);
		ldata = 16'h4f00;
		hi_wr = 1'b1;
		tick;
		hi_wr = 1'b0;
		tick;
		chk("high write", 16'h4f00, hi);
		feed(16'h5000);
		chk("count cleared", 1'b1, alert);
		feed(16'h5000);
		chk("count resumed", 1'b0, alert);
		repeat (2) feed(16'h4a00);
		set_cfg(1'b1, 1'b0, 2'h0);
		feed(16'h5000);
		chk("int alert", 1'b0, alert);
		ara(9'h000);
		chk("ara ack", 1'b0, a);
		chk("ara reply", 8'h9b, d);
		chk("alert cleared", 1'b1, alert);
		feed(16'h4a00);
		chk("low alert", 1'b0, alert);
		ara(9'h190);
		chk("lost reply", 8'h90, d);
		chk("loser holds", 1'b0, alert);
		ara(9'h000);
		chk("retry reply", 8'h9a, d);
		chk("retry clear", 1'b1, alert);
		set_cfg(1'b1, 1'b1, 2'h0);
		feed(16'h5000);
		chk("high pol alert", 1'b1, alert);
		ara(9'h000);
		chk("pol no ara", 1'b1, a);
		set_cfg(1'b1, 1'b0, 2'h0);
		ara(9'h000);
		chk("late ara", 1'b0, a);
		chk("late clear", 1'b1, alert);
		set_cfg(1'b0, 1'b0, 2'h0);
		feed(16'h4a00);
		ara(9'h000);
		chk("cmp no ara", 1'b1, a);
		gc(GC_BYTE, a);
		chk("gc ack", 1'b0, a);
		pins = 3'h3;
		m.wbyte(GC_CMD_LATCH, a);
		m.stop;
		repeat (6) tick;
		chk("relatch", {4'h9, 3'h3}, sa);
		chk("regs kept", 16'h4f00, hi);
		gc(8'h01, a);
		m.stop;
		chk("gc read nak", 1'b1, a);
		ldata = 16'h1000;
		lo_wr = 1'b1;
		tick;
		lo_wr = 1'b0;
		tick;
		gc(GC_BYTE, a);
		pins = 3'h6;
		m.wbyte(GC_CMD_RESET, a);
		m.stop;
		tick;
		chk("busy", 1'b1, busy);
		chk("reset low", 16'h4b00, lo);
		chk("reset high", 16'h5000, hi);
		chk("reset addr", {4'h9, 3'h6}, sa);
		gc(OWN_WR, a);
		m.stop;
		chk("busy own nak", 1'b1, a);
		wait_low(1'b0, 400);
		m.start;
		for (int i = 7; i >= 0; i--)
			m.wbit(OWN_WR[i]);
		// Clock held low while the device drives its acknowledge
		c = 0;
		while (oe !== 1'b1 && c < 20)
		begin
			tick;
			c++;
		end
		chk("own ack", 1'b1, oe);
		chk("sda value", 1'b0, sda_o);
		wait_low(1'b1, 100);
		chk("timeout span", 1'b1, c >= 32 && c <= 44);
		m.stop;
		gc(GC_BYTE, a);
		m.stop;
		chk("fresh start", 1'b0, a);
		ldata = 16'h1000;
		lo_wr = 1'b1;
		tick;
		lo_wr = 1'b0;
		nrst = 1'b0;
		repeat (6) tick;
		nrst = 1'b1;
		repeat (6) tick;
		chk("rerun low", 16'h4b00, lo);
		chk("rerun addr", {4'h9, 3'h6}, sa);
		summarize;
	end
endmodule
`default_nettype wire
